// ===== fce_defines.svh
`ifndef FCE_DEFINES_SVH
`define FCE_DEFINES_SVH

// ****************************************************************
// register map
// ****************************************************************
`define FCE_ADDR_FLAGS    32'h0000_00FC
`define FCE_RESET_FLAGS   8'h00
`define FCE_ADDR_IDX_MSB  31
`define FCE_ADDR_IDX_LSB  2

// ****************************************************************
// flag register field positions
// ****************************************************************
`define FCE_BIT_CARRY     7
`define FCE_BIT_ZERO      6
`define FCE_BIT_SIGN      5
`define FCE_BIT_OVFL      4
`define FCE_BIT_DECADJ    3
`define FCE_BIT_HALF      2
`define FCE_BIT_USER2     1
`define FCE_BIT_USER1     0

// ****************************************************************
// bus encodings
// ****************************************************************
`define FCE_HTRANS_NONSEQ 2'h2
`define FCE_HRESP_OKAY    1'h0
`define FCE_RDATA_ZERO    32'h0000_0000

`endif

// ===== fce_flag_condition_evaluator.sv
// The AHB-Lite register port was left to the implementer.
`include "fce_defines.svh"

module fce_flag_condition_evaluator
(
    input  wire logic                CORE_CLK_IN,
    input  wire logic                RST_IN,
    // ahb-lite slave
    input  wire logic                HSEL_IN,
    input  wire logic [31:0]         HADDR_IN,
    input  wire logic [1:0]          HTRANS_IN,
    input  wire logic                HWRITE_IN,
    input  wire logic [2:0]          HSIZE_IN,
    input  wire logic [31:0]         HWDATA_IN,
    input  wire logic                HREADY_IN,
    output logic                     HREADYOUT_OUT,
    output logic [31:0]              HRDATA_OUT,
    output logic                     HRESP_OUT,
    // arithmetic unit flag update
    input  wire fce_pkg::fce_upd_t   FLAG_UPD_IN,
    // sequencer condition request
    input  wire logic                COND_VALID_IN,
    input  wire fce_pkg::fce_cond_t  COND_CODE_IN,
    output logic                     TAKEN_VALID_OUT,
    output logic                     TAKEN_OUT,
    output fce_pkg::fce_flags_t      FLAGS_OUT
);

    // ****************************************************************
    // condition decode for the answer path
    // ****************************************************************
    // the checks restate each rule from the flags on their own, so a
    // slip in this table cannot hide behind a shared function
    function automatic logic cond_eval(input fce_pkg::fce_cond_t cc,
                                       input fce_pkg::fce_flags_t f);
        logic sxv;
        sxv = f.sign ^ f.ovfl;
        unique case (cc)
            fce_pkg::CC_ALWAYS:               cond_eval = 1'b1;
            fce_pkg::CC_NEVER:                cond_eval = 1'b0;
            fce_pkg::CC_UNSIGNED_BELOW:       cond_eval = f.carry;
            fce_pkg::CC_UNSIGNED_AT_OR_ABOVE: cond_eval = ~f.carry;
            fce_pkg::CC_SIGNED_AT_OR_ABOVE:   cond_eval = ~sxv;
            fce_pkg::CC_SIGNED_BELOW:         cond_eval = sxv;
            fce_pkg::CC_SIGNED_ABOVE:         cond_eval = ~(f.zero | sxv);
            fce_pkg::CC_SIGNED_AT_OR_BELOW:   cond_eval = f.zero | sxv;
            fce_pkg::CC_UNSIGNED_AT_OR_BELOW: cond_eval = f.carry | f.zero;
            fce_pkg::CC_UNSIGNED_ABOVE:       cond_eval = ~f.carry & ~f.zero;
            fce_pkg::CC_EQUAL_TEST:           cond_eval = f.zero;
            fce_pkg::CC_UNEQUAL_TEST:         cond_eval = ~f.zero;
            fce_pkg::CC_NEGATIVE_TEST:        cond_eval = f.sign;
            fce_pkg::CC_POSITIVE_TEST:        cond_eval = ~f.sign;
            fce_pkg::CC_OVERFLOW_SET_TEST:    cond_eval = f.ovfl;
            fce_pkg::CC_OVERFLOW_CLEAR_TEST:  cond_eval = ~f.ovfl;
        endcase
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    fce_pkg::fce_flags_t arith_flag_register_q;
    fce_pkg::fce_flags_t arith_flag_register_d;
    // write data trails its address by a cycle, hence the pending bit
    logic                wr_pend_q;
    logic                wr_pend_d;
    logic [31:0]         rdata_q;
    logic [31:0]         rdata_d;
    logic                hready_q;
    logic                hready_d;
    logic                resp_q;
    logic                resp_d;
    logic                taken_q;
    logic                taken_d;
    logic                tvalid_q;
    logic                tvalid_d;
    logic                addr_phase;
    logic                hit_flags;

    // ****************************************************************
    // bus address phase decode
    // ****************************************************************
    // only the word index is compared, so any byte lane or size hits
    always_comb
    begin
        addr_phase = HSEL_IN & HREADY_IN & HTRANS_IN[1];
        hit_flags  = (HADDR_IN[`FCE_ADDR_IDX_MSB:`FCE_ADDR_IDX_LSB] ==
                      30'(`FCE_ADDR_FLAGS >> `FCE_ADDR_IDX_LSB));
    end

    // read data sampled in the address phase; unmapped words read zero
    always_comb
    begin
        rdata_d   = `FCE_RDATA_ZERO;
        wr_pend_d = addr_phase & HWRITE_IN & hit_flags;
        hready_d  = 1'b1;                // zero wait states
        resp_d    = `FCE_HRESP_OKAY;     // nothing is ever refused
        if (addr_phase && !HWRITE_IN && hit_flags)
        begin
            rdata_d = {24'h00_0000, arith_flag_register_q};
        end
    end

    // ****************************************************************
    // flag register update
    // ****************************************************************
    // arithmetic unit bits win over a bus write in the same cycle,
    // since the instruction result is the newer value;
    // hsize is ignored: any write to the word loads bits 7:0
    always_comb
    begin
        arith_flag_register_d = arith_flag_register_q;
        if (wr_pend_q)
        begin
            arith_flag_register_d = HWDATA_IN[7:0];
        end
        if (FLAG_UPD_IN.we)
        begin
            arith_flag_register_d = (arith_flag_register_d & ~FLAG_UPD_IN.mask) |
                                    (FLAG_UPD_IN.data & FLAG_UPD_IN.mask);
        end
    end

    // ****************************************************************
    // condition evaluation, answered one edge after the request
    // ****************************************************************
    // flags as they stand before the edge: an update in the same cycle
    // is seen by the next request, not this one
    always_comb
    begin
        tvalid_d = COND_VALID_IN;
        taken_d  = COND_VALID_IN & cond_eval(COND_CODE_IN, arith_flag_register_q);
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    // bus side state; ready and response reset to their idle levels so
    // a master that starts right after reset sees a normal bus
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RST_IN)
        begin
            wr_pend_q <= 1'b0;
            rdata_q   <= `FCE_RDATA_ZERO;
            hready_q  <= 1'b1;
            resp_q    <= `FCE_HRESP_OKAY;
        end
        else
        begin
            wr_pend_q <= wr_pend_d;
            rdata_q   <= rdata_d;
            hready_q  <= hready_d;
            resp_q    <= resp_d;
        end
    end

    // flag register
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RST_IN)
        begin
            arith_flag_register_q <= `FCE_RESET_FLAGS;
        end
        else
        begin
            arith_flag_register_q <= arith_flag_register_d;
        end
    end

    // condition answer; cleared in reset so no stale answer leaks out
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RST_IN)
        begin
            taken_q  <= 1'b0;
            tvalid_q <= 1'b0;
        end
        else
        begin
            taken_q  <= taken_d;
            tvalid_q <= tvalid_d;
        end
    end

    // ****************************************************************
    // outputs, all from flip-flops
    // ****************************************************************
    // response is registered too, so every output is a flip-flop
    always_comb
    begin
        HREADYOUT_OUT   = hready_q;
        HRDATA_OUT      = rdata_q;
        HRESP_OUT       = resp_q;
        TAKEN_VALID_OUT = tvalid_q;
        TAKEN_OUT       = taken_q;
        FLAGS_OUT       = arith_flag_register_q;
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    // each condition check restates its rule from the flags one edge back
    a_always_never: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
        COND_VALID_IN && (COND_CODE_IN == fce_pkg::CC_ALWAYS ||
                          COND_CODE_IN == fce_pkg::CC_NEVER)
        |=> TAKEN_VALID_OUT && (TAKEN_OUT == ($past(COND_CODE_IN) == fce_pkg::CC_ALWAYS)))
        else $error("always/never pattern gave wrong answer");

    a_carry_tests: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
        COND_VALID_IN && COND_CODE_IN[2:0] == 3'b111
        |=> TAKEN_OUT == ($past(FLAGS_OUT.carry) ^ $past(COND_CODE_IN[3])))
        else $error("carry test disagrees with carry flag");

    a_signed_cmp: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
        COND_VALID_IN && COND_CODE_IN[2:1] == 2'b00 && COND_CODE_IN[0]
        |=> TAKEN_OUT == ($past(FLAGS_OUT.sign) ^ $past(FLAGS_OUT.ovfl)
                          ^ $past(COND_CODE_IN[3])))
        else $error("signed below/at-or-above test wrong");

    a_signed_gtle: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
        COND_VALID_IN && COND_CODE_IN[2:0] == 3'b010
        |=> TAKEN_OUT == (($past(FLAGS_OUT.zero) | ($past(FLAGS_OUT.sign)
                          ^ $past(FLAGS_OUT.ovfl))) ^ $past(COND_CODE_IN[3])))
        else $error("signed above/at-or-below test wrong");

    a_unsigned_cz: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
        COND_VALID_IN && COND_CODE_IN[2:0] == 3'b011
        |=> TAKEN_OUT == (($past(FLAGS_OUT.carry) | $past(FLAGS_OUT.zero))
                          ^ $past(COND_CODE_IN[3])))
        else $error("unsigned above/at-or-below test wrong");

    a_single_flag: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
        COND_VALID_IN && COND_CODE_IN == fce_pkg::CC_NEGATIVE_TEST
        |=> TAKEN_OUT == $past(FLAGS_OUT.sign))
        else $error("negative test disagrees with sign flag");

    a_zero_tests: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
        COND_VALID_IN && COND_CODE_IN[2:0] == 3'b110
        |=> TAKEN_OUT == ($past(FLAGS_OUT.zero) ^ $past(COND_CODE_IN[3])))
        else $error("zero or nonzero test disagrees with zero flag");

    a_ovfl_tests: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
        COND_VALID_IN && COND_CODE_IN[2:0] == 3'b100
        |=> TAKEN_OUT == ($past(FLAGS_OUT.ovfl) ^ $past(COND_CODE_IN[3])))
        else $error("overflow test disagrees with overflow flag");

    a_positive_test: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
        COND_VALID_IN && COND_CODE_IN == fce_pkg::CC_POSITIVE_TEST
        |=> TAKEN_OUT == !$past(FLAGS_OUT.sign))
        else $error("positive test disagrees with sign flag");

    a_flag_write: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
        addr_phase && HWRITE_IN && hit_flags ##1 !FLAG_UPD_IN.we
        |=> FLAGS_OUT == $past(HWDATA_IN[7:0]))
        else $error("bus write did not reach flag register");

    a_flag_read: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
        addr_phase && !HWRITE_IN && hit_flags
        |=> HRDATA_OUT == {24'h00_0000, $past(FLAGS_OUT)})
        else $error("flag register read returned wrong data");

    a_no_request: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
        !COND_VALID_IN |=> !TAKEN_VALID_OUT && !TAKEN_OUT)
        else $error("answer without a request");

    a_answer_follows: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
        COND_VALID_IN |=> TAKEN_VALID_OUT)
        else $error("request got no answer on the next edge");

    // ****************************************************************
    // read data zero, flag register hold and merge checks
    // ****************************************************************
    a_rdata_zero: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
        !(addr_phase && !HWRITE_IN && hit_flags)
        |=> HRDATA_OUT == `FCE_RDATA_ZERO)
        else $error("read data not zero outside a flag register read");

    a_flag_hold: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
        !wr_pend_q && !FLAG_UPD_IN.we
        |=> FLAGS_OUT == $past(FLAGS_OUT))
        else $error("flag register changed with no write or update");

    a_write_ignored: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
        addr_phase && HWRITE_IN && !hit_flags ##1 !FLAG_UPD_IN.we
        |=> FLAGS_OUT == $past(FLAGS_OUT))
        else $error("write to another word changed the flag register");

    a_masked_update: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
        FLAG_UPD_IN.we && !wr_pend_q
        |=> FLAGS_OUT == (($past(FLAGS_OUT) & ~$past(FLAG_UPD_IN.mask)) |
                          ($past(FLAG_UPD_IN.data) & $past(FLAG_UPD_IN.mask))))
        else $error("masked flag update applied wrongly");

    a_update_wins: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
        FLAG_UPD_IN.we && wr_pend_q
        |=> FLAGS_OUT == (($past(HWDATA_IN[7:0]) & ~$past(FLAG_UPD_IN.mask)) |
                          ($past(FLAG_UPD_IN.data) & $past(FLAG_UPD_IN.mask))))
        else $error("update and bus write in one cycle merged wrongly");

endmodule

// ===== fce_flag_condition_evaluator_tb.sv
module fce_flag_condition_evaluator_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // stimulus and design
    // ****************************************************************
    logic                clk = 1'b0;
    logic                rst = 1'b1;
    logic                hsel = 1'b0;
    logic [31:0]         haddr = '0;
    logic [1:0]          htrans = '0;
    logic                hwrite = 1'b0;
    logic [31:0]         hwdata = '0;
    logic [2:0]          hsize = 3'h0;
    wire logic           hready;
    wire logic [31:0]    hrdata;
    wire logic           hresp;
    wire fce_pkg::fce_upd_t  upd;
    wire logic           cvalid;
    wire fce_pkg::fce_cond_t ccode;
    wire logic           tvalid;
    wire logic           taken;
    wire fce_pkg::fce_flags_t flags;
    int                  bad_count = 0;
    int                  checked = 0;
    logic [31:0]         rd;

    always #12.5 clk = ~clk;

    fce_flag_condition_evaluator DUT (.CORE_CLK_IN(clk), .RST_IN(rst), .HSEL_IN(hsel),
        .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize),
        .HWDATA_IN(hwdata), .HREADY_IN(hready), .HREADYOUT_OUT(hready),
        .HRDATA_OUT(hrdata), .HRESP_OUT(hresp), .FLAG_UPD_IN(upd), .COND_VALID_IN(cvalid),
        .COND_CODE_IN(ccode), .TAKEN_VALID_OUT(tvalid), .TAKEN_OUT(taken),
        .FLAGS_OUT(flags));

    fce_seq_model seq (.clk_in(clk), .upd_out(upd), .valid_out(cvalid), .code_out(ccode));

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic complete_run();
        $display("mismatches %0d, comparisons %0d", bad_count, checked);
        if (bad_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // answer compare: valid must stand with the expected taken bit
    task automatic chk_taken(input logic exp);
        chk({30'h0000_0000, tvalid, taken}, {30'h0000_0000, 1'b1, exp});
    endtask

    // bounded wait for hready, a hang counts as a mismatch
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (hready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            bad_count++;
            complete_run();
        end
    endtask

    // single word transfer: address phase, then data phase
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'h2;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        chk({31'h0000_0000, hresp}, 32'h0000_0000);
    endtask

    // reference decode: f is {carry, zero, sign, overflow}
    function automatic logic ref_taken(input logic [3:0] c, input logic [3:0] f);
        logic [15:0] t;
        logic        x;
        x = f[1] ^ f[0];
        t = {!f[3], !f[2], !f[1], !f[0], !f[3] & !f[2], !(f[2] | x), !x, 1'b1,
             f[3], f[2], f[1], f[0], f[3] | f[2], f[2] | x, x, 1'b0};
        return t[c];
    endfunction

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        #1 chk({24'h0, flags}, 32'h0000_0000);
        bus(1'b0, 32'h0000_00FC, 32'h0);
        chk(rd, 32'h0000_0000);
        bus(1'b1, 32'h0000_00FC, 32'hFFFF_FFA5);
        bus(1'b1, 32'h0000_00F8, 32'h0000_005A);
        bus(1'b0, 32'h0000_00F8, 32'h0);
        chk(rd, 32'h0000_0000);
        bus(1'b0, 32'h0000_00FC, 32'h0);
        chk(rd, 32'h0000_00A5);
        // every code against every carry, zero, sign, overflow mix
        for (int f = 0; f < 16; f++)
        begin
            bus(1'b1, 32'h0000_00FC, {24'h0, f[3:0], 4'h3});
            for (int c = 0; c < 16; c++)
            begin
                seq.ask(fce_pkg::fce_cond_t'(c[3:0]));
                #1 chk_taken(ref_taken(c[3:0], f[3:0]));
            end
        end
        // masked update clears carry only
        seq.update(8'h80, 8'h00);
        #1 chk({24'h0, flags}, 32'h0000_0073);
        seq.ask(fce_pkg::CC_UNSIGNED_BELOW);
        #1 chk_taken(1'b0);
        // bus write and update in one cycle: the update's bits win
        fork
            bus(1'b1, 32'h0000_00FC, 32'h0000_0000);
            begin
                @(posedge clk);
                seq.update(8'h80, 8'h80);
            end
        join
        #1 chk({24'h0, flags}, 32'h0000_0080);
        seq.ask(fce_pkg::CC_UNSIGNED_BELOW);
        #1 chk_taken(1'b1);
        complete_run();
    end
endmodule

// ===== fce_pkg.sv
package fce_pkg;

    // ****************************************************************
    // flag register layout, bit 7 down to bit 0
    // ****************************************************************
    typedef struct packed {
        logic carry;
        logic zero;
        logic sign;
        logic ovfl;
        logic decadj;
        logic half;
        logic user2;
        logic user1;
    } fce_flags_t;

    // ****************************************************************
    // condition field encodings
    // ****************************************************************
    typedef enum logic [3:0] {
        CC_NEVER                = 4'b0000,
        CC_SIGNED_BELOW         = 4'b0001,
        CC_SIGNED_AT_OR_BELOW   = 4'b0010,
        CC_UNSIGNED_AT_OR_BELOW = 4'b0011,
        CC_OVERFLOW_SET_TEST    = 4'b0100,
        CC_NEGATIVE_TEST        = 4'b0101,
        CC_EQUAL_TEST           = 4'b0110,
        CC_UNSIGNED_BELOW       = 4'b0111,
        CC_ALWAYS               = 4'b1000,
        CC_SIGNED_AT_OR_ABOVE   = 4'b1001,
        CC_SIGNED_ABOVE         = 4'b1010,
        CC_UNSIGNED_ABOVE       = 4'b1011,
        CC_OVERFLOW_CLEAR_TEST  = 4'b1100,
        CC_POSITIVE_TEST        = 4'b1101,
        CC_UNEQUAL_TEST         = 4'b1110,
        CC_UNSIGNED_AT_OR_ABOVE = 4'b1111
    } fce_cond_t;

    // ****************************************************************
    // flag update from the arithmetic unit
    // ****************************************************************
    typedef struct packed {
        logic       we;
        fce_flags_t mask;
        fce_flags_t data;
    } fce_upd_t;

endpackage

// ===== fce_seq_model.sv
// ****************************************************************
// sequencer and arithmetic unit stand-in
// ****************************************************************
module fce_seq_model
(
    input  wire logic           clk_in,
    output fce_pkg::fce_upd_t   upd_out,
    output logic                valid_out,
    output fce_pkg::fce_cond_t  code_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle lines show inverted last values, never a stale copy
    initial
    begin
        upd_out <= '0;
        valid_out <= 1'b0;
        code_out <= fce_pkg::CC_NEVER;
    end

    // one-cycle condition request, released right after its edge
    task automatic ask(input fce_pkg::fce_cond_t c);
        @(posedge clk_in);
        valid_out <= 1'b1;
        code_out <= c;
        @(posedge clk_in);
        valid_out <= 1'b0;
        code_out <= fce_pkg::fce_cond_t'(~c);
    endtask

    // one-cycle masked flag update pulse
    task automatic update(input logic [7:0] m, input logic [7:0] d);
        @(posedge clk_in);
        upd_out <= {1'b1, m, d};
        @(posedge clk_in);
        upd_out <= {1'b0, ~m, ~d};
    endtask
endmodule
